// >>> shared/prc_pkg.sv
package prc_pkg;
  // ----------------------------------------------------------------
  // register offsets (register index on the plain port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RGMII_CTL = 8'h32;
  localparam logic [7:0] ADDR_RGMII_CTL2 = 8'h33;
  localparam logic [7:0] ADDR_FE_CFG = 8'h34;
  localparam logic [7:0] ADDR_VITERBI_CFG = 8'h53;
  localparam logic [7:0] ADDR_SKEW_STS = 8'h55;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RGC_EN_BIT = 7;
  localparam int RGC_RXTHR_LSB = 5;
  localparam int RGC_TXTHR_LSB = 3;
  localparam int RGC_TXDLY_BIT = 1;
  localparam int RGC_RXDLY_BIT = 0;
  localparam int RGC2_BYPASS_BIT = 4;
  localparam int FE_TMODIS_BIT = 11;
  localparam int FE_RECOV_LSB = 7;
  localparam int FE_FORCE_BIT = 6;
  localparam int FE_TERN_BIT = 5;
  localparam int FE_GAP_BIT = 4;
  localparam int FE_DECBYP_BIT = 3;
  localparam int FE_SCRDIS_BIT = 2;
  localparam int FE_ODD_BIT = 1;
  localparam int FE_EARLY_BIT = 0;
  localparam int SKEW_B_LSB = 4;
  localparam int SKEW_A_LSB = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_RGC_EN_FIXED = 1'h1;
  localparam logic [1:0] RST_FIFO_THR = 2'h2;
  localparam logic RST_CLK_DELAY = 1'h1;
  localparam logic RST_BYPASS = 1'h0;
  localparam logic [3:0] RST_RECOV_TIME = 4'hF;
  localparam logic RST_TERN = 1'h1;
  localparam logic [3:0] RST_IDLE_LIMIT = 4'h5;
  localparam logic [15:0] VITERBI_RSVD = 16'h2050;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int TIMEOUT_US = 1500;
  localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1000000);
  localparam int MS_CYC = CLK_HZ / 1000;
endpackage

// >>> core/prc_regs.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module prc_regs
  import prc_pkg::*;
#(
  parameter bit STRAPPED_VARIANT = 1'b0,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int MS_CYCLES = MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // strap and receive-path status pins
  input wire logic strapEnablePin,
  input wire logic rxPacketActive,
  input wire logic descramblerLocked,
  input wire logic linkQualified,
  input wire logic [3:0] channelASkew,
  input wire logic [3:0] channelBSkew,
  // controls to the datapaths
  output logic interfaceEnable,
  output logic [1:0] rxFifoMidlevelThreshold,
  output logic [1:0] txFifoMidlevelThreshold,
  output logic txClockShift,
  output logic rxClockShift,
  output logic asyncFifoBypass,
  output logic enhancedTernaryDetect,
  output logic enhancedGapDetect,
  output logic rxBlockDecoderBypass,
  output logic scramblerDisable,
  output logic oddNibbleDetect,
  output logic earlyReceiveValid,
  output logic [3:0] viterbiIdleCountLimit,
  output logic linkGood100,
  output logic rxAbort
);

  initial begin
    if (TIMEOUT_CYCLES < 1 || MS_CYCLES < 1) begin
      $error("prc_regs: cycle counts must be at least one");
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  logic [5:0] syncA;
  logic [5:0] syncB;
  logic [5:0] syncC;
  logic [5:0] pinsClean;
  logic [3:0] skewA;
  logic [3:0] skewB;
  logic [3:0] skewA1;
  logic [3:0] skewA2;
  logic [3:0] skewB1;
  logic [3:0] skewB2;
  wire [5:0] pinsRaw = {strapEnablePin, rxPacketActive, descramblerLocked,
    linkQualified, 2'h0};
  wire [5:0] pinsAgree = ~(syncB ^ syncC);
  wire [5:0] next_pinsClean = (pinsAgree & syncC) | (~pinsAgree & pinsClean);
  wire skewAAgree = (skewA2 == skewA1);
  wire skewBAgree = (skewB2 == skewB1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA <= 6'h00;
      syncB <= 6'h00;
      syncC <= 6'h00;
      pinsClean <= 6'h00;
    end else if (clkEn) begin
      syncA <= pinsRaw;
      syncB <= syncA;
      syncC <= syncB;
      pinsClean <= next_pinsClean;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skewA <= 4'h0;
      skewA1 <= 4'h0;
      skewA2 <= 4'h0;
      skewB <= 4'h0;
      skewB1 <= 4'h0;
      skewB2 <= 4'h0;
    end else if (clkEn) begin
      skewA <= channelASkew;
      skewA1 <= skewA;
      skewA2 <= skewA1;
      skewB <= channelBSkew;
      skewB1 <= skewB;
      skewB2 <= skewB1;
    end
  end

  wire strapLevel = pinsClean[5];
  wire pktActive = pinsClean[4];
  wire descLocked = pinsClean[3];
  wire linkOk = pinsClean[2];

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire hitCtl = (regAddr == ADDR_RGMII_CTL);
  wire hitCtl2 = (regAddr == ADDR_RGMII_CTL2);
  wire hitFe = (regAddr == ADDR_FE_CFG);
  wire hitVit = (regAddr == ADDR_VITERBI_CFG);
  wire hitSkew = (regAddr == ADDR_SKEW_STS);
  wire wrCtl = regWr & hitCtl;
  wire wrCtl2 = regWr & hitCtl2;
  wire wrFe = regWr & hitFe;
  wire wrVit = regWr & hitVit;

  // ----------------------------------------------------------------
  // writable fields
  // ----------------------------------------------------------------
  logic strapTaken;
  logic [3:0] recoveryTime;
  logic timerDisable;
  logic forceLinkGood;

  // strapped variant latches strapLevel once, in the first enabled cycle after reset, while the synchronisers still hold zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interfaceEnable <= RST_RGC_EN_FIXED;
      strapTaken <= 1'b0;
    end else if (clkEn) begin
      if (wrCtl) begin
        interfaceEnable <= regWdata[RGC_EN_BIT];
        strapTaken <= 1'b1;
      end else if (STRAPPED_VARIANT && !strapTaken) begin
        interfaceEnable <= strapLevel;
        strapTaken <= 1'b1;
      end
    end
  end

  // only defined bits are stored; the rest are never held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxFifoMidlevelThreshold <= RST_FIFO_THR;
      txFifoMidlevelThreshold <= RST_FIFO_THR;
      txClockShift <= RST_CLK_DELAY;
      rxClockShift <= RST_CLK_DELAY;
    end else if (clkEn && wrCtl) begin
      rxFifoMidlevelThreshold <= regWdata[RGC_RXTHR_LSB +: 2];
      txFifoMidlevelThreshold <= regWdata[RGC_TXTHR_LSB +: 2];
      txClockShift <= regWdata[RGC_TXDLY_BIT];
      rxClockShift <= regWdata[RGC_RXDLY_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      asyncFifoBypass <= RST_BYPASS;
    end else if (clkEn && wrCtl2) begin
      asyncFifoBypass <= regWdata[RGC2_BYPASS_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerDisable <= 1'b0;
      recoveryTime <= RST_RECOV_TIME;
      forceLinkGood <= 1'b0;
      enhancedTernaryDetect <= RST_TERN;
      enhancedGapDetect <= 1'b0;
      rxBlockDecoderBypass <= 1'b0;
      scramblerDisable <= 1'b0;
      oddNibbleDetect <= 1'b0;
      earlyReceiveValid <= 1'b0;
    end else if (clkEn && wrFe) begin
      timerDisable <= regWdata[FE_TMODIS_BIT];
      recoveryTime <= regWdata[FE_RECOV_LSB +: 4];
      forceLinkGood <= regWdata[FE_FORCE_BIT];
      enhancedTernaryDetect <= regWdata[FE_TERN_BIT];
      enhancedGapDetect <= regWdata[FE_GAP_BIT];
      rxBlockDecoderBypass <= regWdata[FE_DECBYP_BIT];
      scramblerDisable <= regWdata[FE_SCRDIS_BIT];
      oddNibbleDetect <= regWdata[FE_ODD_BIT];
      earlyReceiveValid <= regWdata[FE_EARLY_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      viterbiIdleCountLimit <= RST_IDLE_LIMIT;
    end else if (clkEn && wrVit) begin
      viterbiIdleCountLimit <= regWdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // descrambler timeout and recovery
  // ----------------------------------------------------------------
  // a packet running past the limit is cut; after an unlock the
  // link stays unqualified for the programmed number of ms
  logic [31:0] pktCount;
  logic [31:0] msCount;
  logic [3:0] recovLeft;
  logic descLockedD;
  wire pktOver = (pktCount >= 32'(TIMEOUT_CYCLES));
  wire unlockEdge = descLockedD & ~descLocked;
  wire msTick = (msCount >= 32'(MS_CYCLES - 1));
  wire recovering = (recovLeft != 4'h0);
  wire next_rxAbort = pktActive & pktOver & ~timerDisable;
  wire next_linkGood = forceLinkGood | (linkOk & ~recovering);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pktCount <= 32'h0;
    end else if (clkEn) begin
      if (!pktActive) begin
        pktCount <= 32'h0;
      end else if (!pktOver) begin
        pktCount <= pktCount + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      descLockedD <= 1'b0;
      msCount <= 32'h0;
      recovLeft <= 4'h0;
    end else if (clkEn) begin
      descLockedD <= descLocked;
      if (unlockEdge) begin
        recovLeft <= recoveryTime;
        msCount <= 32'h0;
      end else if (recovering) begin
        msCount <= msTick ? 32'h0 : msCount + 32'h1;
        if (msTick) begin
          recovLeft <= recovLeft - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxAbort <= 1'b0;
      linkGood100 <= 1'b0;
    end else if (clkEn) begin
      rxAbort <= next_rxAbort;
      linkGood100 <= next_linkGood;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // thresholds read back as written even while bypass hides them
  wire [15:0] rdCtl = {8'h00, interfaceEnable, rxFifoMidlevelThreshold,
    txFifoMidlevelThreshold, 1'b0, txClockShift, rxClockShift};
  wire [15:0] rdCtl2 = {11'h000, asyncFifoBypass, 4'h0};
  wire [15:0] rdFe = {4'h0, timerDisable, recoveryTime, forceLinkGood,
    enhancedTernaryDetect, enhancedGapDetect, rxBlockDecoderBypass,
    scramblerDisable, oddNibbleDetect, earlyReceiveValid};
  wire [15:0] rdVit = VITERBI_RSVD | {12'h000, viterbiIdleCountLimit};
  wire [15:0] rdSkew = {8'h00, skewBHeld, skewAHeld};
  wire [15:0] next_regRdata = hitCtl ? rdCtl : hitCtl2 ? rdCtl2 :
    hitFe ? rdFe : hitVit ? rdVit : hitSkew ? rdSkew : 16'h0000;

  logic [3:0] skewAHeld;
  logic [3:0] skewBHeld;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skewAHeld <= 4'h0;
      skewBHeld <= 4'h0;
    end else if (clkEn) begin
      if (skewAAgree) begin
        skewAHeld <= skewA2;
      end
      if (skewBAgree) begin
        skewBHeld <= skewB2;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= 16'h0000;
    end else if (clkEn) begin
      regRdata <= regRd ? next_regRdata : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // fifo threshold masking under bypass
  // ----------------------------------------------------------------
  // the datapath must ignore thresholds while asyncFifoBypass is high;
  // the threshold outputs stay as programmed so software sees no loss
  // consumers gate rx/txFifoMidlevelThreshold with asyncFifoBypass

endmodule

// >>> verif/prc_regs_properties.sv
`timescale 1ns/100ps
module prc_regs_checker
  import prc_pkg::*;
(
  // clock and register port
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  // controls and status
  input wire logic interfaceEnable,
  input wire logic [1:0] rxFifoMidlevelThreshold,
  input wire logic [1:0] txFifoMidlevelThreshold,
  input wire logic txClockShift,
  input wire logic rxClockShift,
  input wire logic asyncFifoBypass,
  input wire logic scramblerDisable,
  input wire logic [3:0] viterbiIdleCountLimit,
  input wire logic rxPacketActive,
  input wire logic rxAbort
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic wrCtl = clkEn && regWr && regAddr == ADDR_RGMII_CTL;
  wire logic wrCtl2 = clkEn && regWr && regAddr == ADDR_RGMII_CTL2;
  wire logic wrFe = clkEn && regWr && regAddr == ADDR_FE_CFG;
  wire logic wrVit = clkEn && regWr && regAddr == ADDR_VITERBI_CFG;
  wire logic rdCtl = clkEn && regRd && regAddr == ADDR_RGMII_CTL;
  wire logic rdSkew = clkEn && regRd && regAddr == ADDR_SKEW_STS;
  // ------------
  // properties
  // ------------
  property p_rd_idle;
    (clkEn && !regRd) |=> regRdata == 16'h0000;
  endproperty
  property p_ctl_rsvd;
    rdCtl |=> regRdata[15:8] == 8'h00 && !regRdata[2];
  endproperty
  property p_enable;
    wrCtl |=> interfaceEnable == $past(regWdata[RGC_EN_BIT]);
  endproperty
  property p_thresh;
    wrCtl |=> {rxFifoMidlevelThreshold, txFifoMidlevelThreshold}
      == $past(regWdata[6:3]);
  endproperty
  property p_thr_hold;
    !wrCtl |=> $stable(rxFifoMidlevelThreshold)
      && $stable(txFifoMidlevelThreshold);
  endproperty
  property p_clk_shift;
    wrCtl |=> {txClockShift, rxClockShift} == $past(regWdata[1:0]);
  endproperty
  property p_bypass;
    wrCtl2 |=> asyncFifoBypass == $past(regWdata[RGC2_BYPASS_BIT]);
  endproperty
  property p_scramble;
    wrFe |=> scramblerDisable == $past(regWdata[FE_SCRDIS_BIT]);
  endproperty
  property p_idle;
    wrVit |=> viterbiIdleCountLimit == $past(regWdata[3:0]);
  endproperty
  property p_skew_rsvd;
    rdSkew |=> regRdata[15:8] == 8'h00;
  endproperty
  // abort must clear once the packet has been gone long enough to sync
  property p_abort_end;
    !rxPacketActive [*8] |-> !rxAbort;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved bits set");
  a_enable: assert property (p_enable) else $error("enable wrong");
  a_thresh: assert property (p_thresh) else $error("threshold wrong");
  a_thr_hold: assert property (p_thr_hold) else $error("threshold moved");
  a_clk_shift: assert property (p_clk_shift) else $error("shift wrong");
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  a_scramble: assert property (p_scramble) else $error("scrambler wrong");
  a_idle: assert property (p_idle) else $error("idle limit wrong");
  a_skew_rsvd: assert property (p_skew_rsvd) else $error("skew upper set");
  a_abort_end: assert property (p_abort_end) else $error("abort stuck");
  c_ctl_write: cover property (wrCtl);
  c_abort: cover property ($rose(rxAbort));
  c_skew: cover property (rdSkew ##1 regRdata != 16'h0000);
endmodule
bind prc_regs prc_regs_checker chk_u (
  .clk(clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .interfaceEnable(interfaceEnable),
  .rxFifoMidlevelThreshold(rxFifoMidlevelThreshold),
  .txFifoMidlevelThreshold(txFifoMidlevelThreshold),
  .txClockShift(txClockShift), .rxClockShift(rxClockShift),
  .asyncFifoBypass(asyncFifoBypass), .scramblerDisable(scramblerDisable),
  .viterbiIdleCountLimit(viterbiIdleCountLimit),
  .rxPacketActive(rxPacketActive), .rxAbort(rxAbort));

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import prc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic rxPacketActive = 1'b0;
  logic descramblerLocked = 1'b1;
  logic linkQualified = 1'b1;
  logic [3:0] skewA = 4'h0;
  logic [3:0] skewB = 4'h0;
  logic [15:0] regRdata, q;
  logic interfaceEnable, txClockShift, rxClockShift, asyncFifoBypass;
  logic enhancedTernaryDetect, enhancedGapDetect, rxBlockDecoderBypass;
  logic scramblerDisable, oddNibbleDetect, earlyReceiveValid;
  logic linkGood100, rxAbort;
  logic [1:0] rxThr, txThr;
  logic [3:0] idleLimit;
  int error_cnt = 0;
  int cmp_count = 0;
  wire logic [15:0] ctlOuts = {2'h0, asyncFifoBypass, interfaceEnable, rxThr,
    txThr, txClockShift, rxClockShift, enhancedTernaryDetect,
    enhancedGapDetect, rxBlockDecoderBypass, scramblerDisable,
    oddNibbleDetect, earlyReceiveValid};
  // write and read-back table: address, data, read value, control outputs
  localparam logic [7:0] TA [10] = '{8'h32, 8'h32, 8'h33, 8'h33, 8'h34,
    8'h34, 8'h53, 8'h53, 8'h55, 8'h40};
  localparam logic [15:0] TW [10] = '{16'hFFFF, 16'h00A9, 16'hFFFF,
    16'h0000, 16'hFFFF, 16'h0855, 16'hFFFF, 16'h0004, 16'hFFFF, 16'hFFFF};
  localparam logic [15:0] TR [10] = '{16'h00FB, 16'h00A9, 16'h0010,
    16'h0000, 16'h0FFF, 16'h0855, 16'h205F, 16'h2054, 16'h0000, 16'h0000};
  localparam logic [15:0] TO [10] = '{16'h1FE0, 16'h1560, 16'h3560,
    16'h1560, 16'h157F, 16'h1555, 16'h1555, 16'h1555, 16'h1555, 16'h1555};
  always #12.5 clk = ~clk;
  // short counts keep the timeout and recovery scenarios quick
  prc_regs #(.TIMEOUT_CYCLES(20), .MS_CYCLES(5)) dut_u (
    .clk(clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .strapEnablePin(1'b0), .rxPacketActive(rxPacketActive),
    .descramblerLocked(descramblerLocked), .linkQualified(linkQualified),
    .channelASkew(skewA), .channelBSkew(skewB),
    .interfaceEnable(interfaceEnable), .rxFifoMidlevelThreshold(rxThr),
    .txFifoMidlevelThreshold(txThr), .txClockShift(txClockShift),
    .rxClockShift(rxClockShift), .asyncFifoBypass(asyncFifoBypass),
    .enhancedTernaryDetect(enhancedTernaryDetect),
    .enhancedGapDetect(enhancedGapDetect),
    .rxBlockDecoderBypass(rxBlockDecoderBypass),
    .scramblerDisable(scramblerDisable), .oddNibbleDetect(oddNibbleDetect),
    .earlyReceiveValid(earlyReceiveValid),
    .viterbiIdleCountLimit(idleLimit), .linkGood100(linkGood100),
    .rxAbort(rxAbort));
  // ------------
  // bus tasks
  // ------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk("read data", exp, regRdata);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ------------
  // scenarios
  // ------------
  task automatic t_reset();
    rdchk(ADDR_RGMII_CTL, 16'h00D3);
    rdchk(ADDR_RGMII_CTL2, 16'h0000);
    rdchk(ADDR_FE_CFG, 16'h07A0);
    rdchk(ADDR_VITERBI_CFG, 16'h2055);
    chk("control outputs", 16'h1AE0, ctlOuts);
  endtask
  task automatic t_fields();
    for (int i = 0; i < 10; i++) begin
      wr(TA[i], TW[i]);
      #1 chk("control outputs", TO[i], ctlOuts);
      rdchk(TA[i], TR[i]);
    end
    chk("idle limit", 16'h0004, {12'h000, idleLimit});
  endtask
  task automatic t_link();
    @(posedge clk) linkQualified <= 1'b0;
    waitc(8);
    chk("forced link", 16'h0001, {15'h0, linkGood100});
    wr(ADDR_FE_CFG, 16'h0100);
    waitc(8);
    chk("unforced link", 16'h0000, {15'h0, linkGood100});
    @(posedge clk) linkQualified <= 1'b1;
    waitc(8);
    chk("qualified link", 16'h0001, {15'h0, linkGood100});
    @(posedge clk) descramblerLocked <= 1'b0;
    waitc(2);
    @(posedge clk) descramblerLocked <= 1'b1;
    waitc(8);
    chk("recovering link", 16'h0000, {15'h0, linkGood100});
    waitc(20);
    chk("recovered link", 16'h0001, {15'h0, linkGood100});
  endtask
  task automatic t_abort();
    @(posedge clk) rxPacketActive <= 1'b1;
    waitc(12);
    chk("early abort", 16'h0000, {15'h0, rxAbort});
    waitc(23);
    chk("long packet abort", 16'h0001, {15'h0, rxAbort});
    @(posedge clk) rxPacketActive <= 1'b0;
    waitc(8);
    chk("abort cleared", 16'h0000, {15'h0, rxAbort});
    wr(ADDR_FE_CFG, 16'h0900);
    @(posedge clk) rxPacketActive <= 1'b1;
    waitc(35);
    chk("timer disabled", 16'h0000, {15'h0, rxAbort});
    @(posedge clk) rxPacketActive <= 1'b0;
  endtask
  task automatic t_skew();
    @(posedge clk) begin
      skewA <= 4'h3;
      skewB <= 4'hA;
    end
    waitc(8);
    rdchk(ADDR_SKEW_STS, 16'h00A3);
    wr(ADDR_SKEW_STS, 16'h0000);
    rdchk(ADDR_SKEW_STS, 16'h00A3);
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_link();
    t_abort();
    t_skew();
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
